/* File: rtl/ssp_i2c_slave.v */
// Two-wire serial port: slave engine, Start/Stop tracking, register slave
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ssp_i2c_regs.vh"
module ssp_i2c_slave (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [11:0] adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output wire        ack_o,
  input  wire        scl_i,
  output wire        scl_o,
  output reg         scl_oe_o,
  input  wire        sda_i,
  output wire        sda_o,
  output reg         sda_oe_o,
  output reg         irq_o
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_RX    = 3'd1;
  localparam [2:0] ST_ACK   = 3'd2;
  localparam [2:0] ST_TX    = 3'd3;
  localparam [2:0] ST_TXACK = 3'd4;
  localparam [2:0] ST_SKIP  = 3'd5;

  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  reg [7:0] gic_q;
  reg [7:0] tris_q;
  reg [7:0] adr_q;
  reg [7:0] buf_q;
  reg [7:0] sr_q;
  reg [3:0] mode_q;
  reg       en_q;
  reg       ckp_q;
  reg       ov_q;
  reg       wcol_q;
  reg       ie_q;
  reg       flag_q;
  reg       bf_q;
  reg       ua_q;
  reg       rw_q;
  reg       da_q;
  reg       s_q;
  reg       p_q;
  reg [1:0] stat_hi_q;
  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg       ack_q;
  reg       first_q;
  reg       tenlow_q;
  reg       tenm_q;
  reg       wb_ack_q;

  // ----------------------------------------------------------------
  // Line synchroniser
  // ----------------------------------------------------------------
  line_sync u_sync (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .scl_o      (scl_s),
    .sda_o      (sda_s),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (start_det),
    .stop_o     (stop_det)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire slave_en = en_q & (mode_q[2:1] == 2'b11);                    // R23
  wire ten_bit  = mode_q[0];                                        // R23
  wire sp_int   = en_q & ((mode_q == `MODE_S7SP) | (mode_q == `MODE_S10SP)
                  | (mode_q == `MODE_FWM));                         // R23
  wire fw_mstr  = en_q & (mode_q == `MODE_FWM);

  // Bus access decode; write lands on the edge where ack is seen
  wire [9:0] idx   = adr_i[11:2];
  wire       acc   = cyc_i & stb_i & wb_ack_q;
  wire       wr    = acc & we_i & sel_i[0];
  wire       rd    = acc & ~we_i;
  wire [7:0] wdat  = dat_i[7:0];
  wire       wr_buf = wr & (idx == `BUF_IDX);
  wire       wr_con = wr & (idx == `CON_IDX);
  wire       wr_adr = wr & (idx == `ADR_IDX);
  wire       wr_pir = wr & (idx == `PIRF_IDX);
  wire       rd_buf = rd & (idx == `BUF_IDX);

  // Byte-end decision inputs at the eighth falling edge
  wire addr_hit  = (sr_q[7:1] == adr_q[7:1]);                       // R3
  wire ten_first = (sr_q[7:3] == `TEN_PREFIX);                      // R6
  wire low_hit   = (sr_q == adr_q);
  wire take_ok   = ~bf_q & ~ov_q;                                   // R4 R5
  wire in_tx     = (st_q == ST_TX);
  wire tx_busy   = in_tx & (cnt_q != 4'd0);

  // ----------------------------------------------------------------
  // Wishbone classic slave, one wait state, zero for unmapped
  // ----------------------------------------------------------------
  assign ack_o = wb_ack_q;

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wb_ack_q <= 1'b0;
      dat_o    <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_q <= cyc_i & stb_i & ~wb_ack_q;
      dat_o    <= 32'h0000_0000;
      if (cyc_i & stb_i & ~wb_ack_q & ~we_i)
      begin
        case (idx)
          `GIC_IDX:  dat_o[7:0] <= gic_q;
          `PIRF_IDX: dat_o[7:0] <= {4'h0, flag_q, 3'h0};
          `BUF_IDX:  dat_o[7:0] <= buf_q;
          `CON_IDX:  dat_o[7:0] <= {wcol_q, ov_q, en_q, ckp_q, mode_q};
          `TRIS_IDX: dat_o[7:0] <= tris_q;
          `PIEN_IDX: dat_o[7:0] <= {4'h0, ie_q, 3'h0};
          `ADR_IDX:  dat_o[7:0] <= adr_q;
          `STAT_IDX: dat_o[7:0] <= {stat_hi_q, da_q, p_q, s_q, rw_q, ua_q, bf_q};
          default:   dat_o[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Plain software registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gic_q     <= `GIC_RST;
      tris_q    <= `TRIS_RST;
      adr_q     <= `ADR_RST;
      mode_q    <= 4'h0;
      en_q      <= 1'b0;
      ie_q      <= 1'b0;
      stat_hi_q <= 2'b00;
    end
    else
    begin
      if (wr & (idx == `GIC_IDX))
        gic_q <= wdat;
      if (wr & (idx == `TRIS_IDX))
        tris_q <= wdat;
      if (wr_adr)
        adr_q <= wdat;
      if (wr & (idx == `PIEN_IDX))
        ie_q <= wdat[`PIR_FLAG];
      if (wr & (idx == `STAT_IDX))
        stat_hi_q <= wdat[7:6];
      if (wr_con)
      begin
        mode_q <= wdat[3:0];
        en_q   <= wdat[`CON_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus engine: Start/Stop, shifting, matching, acknowledge
  // Hardware sets beat software clears in the same cycle
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q     <= ST_IDLE;
      cnt_q    <= 4'd0;
      sr_q     <= 8'h00;
      buf_q    <= 8'h00;
      ack_q    <= 1'b0;
      first_q  <= 1'b0;
      tenlow_q <= 1'b0;
      tenm_q   <= 1'b0;
      flag_q   <= 1'b0;
      bf_q     <= 1'b0;
      ov_q     <= 1'b0;
      wcol_q   <= 1'b0;
      ckp_q    <= 1'b0;
      ua_q     <= 1'b0;
      rw_q     <= 1'b0;
      da_q     <= 1'b0;
      s_q      <= 1'b0;
      p_q      <= 1'b0;
    end
    else
    begin
      // Software clears first; engine sets below override them
      if (wr_pir)
        flag_q <= wdat[`PIR_FLAG];
      if (rd_buf)
        bf_q <= 1'b0;                                               // R25
      if (wr_con)
      begin
        ov_q   <= wdat[`CON_OV];                                    // R25
        wcol_q <= wdat[`CON_WCOL];
        ckp_q  <= wdat[`CON_CKP];                                   // R24
      end
      if (wr_adr)
        ua_q <= 1'b0;                                               // R8
      // Buffer write; in transmit it also primes the shifter
      if (wr_buf)
      begin
        if (tx_busy)
          wcol_q <= 1'b1;
        else
        begin
          buf_q <= wdat;
          if (in_tx)
            sr_q <= wdat;                                           // R12
        end
      end

      if (~en_q)
      begin
        // Disabled port forgets bus state
        st_q     <= ST_IDLE;
        s_q      <= 1'b0;                                           // R16
        p_q      <= 1'b0;                                           // R16
        ua_q     <= 1'b0;
        tenm_q   <= 1'b0;
        tenlow_q <= 1'b0;
        ack_q    <= 1'b0;
      end
      else if (start_det)
      begin
        // Start or repeated Start restarts the byte engine
        s_q      <= 1'b1;                                           // R16
        p_q      <= 1'b0;
        cnt_q    <= 4'd0;
        first_q  <= 1'b1;
        ack_q    <= 1'b0;
        st_q     <= slave_en ? ST_RX : ST_SKIP;                     // R1 R22
        if (sp_int)
          flag_q <= 1'b1;                                           // R19
      end
      else if (stop_det)
      begin
        // A Stop on a busy bus also wakes an armed firmware master
        s_q      <= 1'b0;
        p_q      <= 1'b1;                                           // R16 R17
        st_q     <= ST_IDLE;
        ack_q    <= 1'b0;
        tenm_q   <= 1'b0;
        tenlow_q <= 1'b0;
        if (sp_int)
          flag_q <= 1'b1;                                           // R19 R20
      end
      else
      begin
        case (st_q)
          ST_RX:
          begin
            if (scl_rise & (cnt_q < 4'd8))
            begin
              sr_q  <= {sr_q[6:0], sda_s};                          // R2
              cnt_q <= cnt_q + 4'd1;
            end
            else if (scl_fall & (cnt_q == 4'd8))
            begin
              st_q  <= ST_ACK;
              ack_q <= 1'b0;
              if (first_q & ~(addr_hit & (~ten_bit | ten_first)))
                st_q <= ST_SKIP;
              else if (first_q & ten_bit & sr_q[0] & ~tenm_q)
                st_q <= ST_SKIP;                                    // R7
              else
              begin
                da_q <= ~first_q & ~tenlow_q;
                if (first_q)
                  rw_q <= sr_q[0];                                  // R9 R11
                if (ten_bit & (first_q ? ~sr_q[0] : tenlow_q))
                  ua_q <= 1'b1;                                     // R8
                if (first_q & ten_bit & ~sr_q[0])
                begin
                  tenlow_q <= 1'b1;
                  tenm_q   <= 1'b0;
                end
                if (tenlow_q)
                begin
                  tenlow_q <= 1'b0;
                  tenm_q   <= low_hit;
                  if (~low_hit)
                  begin
                    st_q <= ST_SKIP;
                    ua_q <= 1'b0;
                  end
                end
                if (~tenlow_q | low_hit)
                begin
                  if (take_ok)
                  begin
                    buf_q <= sr_q;                                  // R4 R9
                    bf_q  <= 1'b1;                                  // R4
                    ack_q <= 1'b1;                                  // R4
                  end
                  else if (bf_q)
                    ov_q <= 1'b1;                                   // R5
                end
              end
            end
          end
          ST_ACK:
          begin
            if (scl_rise)
              cnt_q <= 4'd9;
            else if (scl_fall & (cnt_q == 4'd9))
            begin
              // Ninth falling edge ends the ACK slot
              ack_q   <= 1'b0;
              cnt_q   <= 4'd0;
              first_q <= 1'b0;
              flag_q  <= 1'b1;                                      // R4 R5 R10
              if (rw_q & ~tenlow_q & ack_q)
              begin
                st_q  <= ST_TX;
                ckp_q <= 1'b0;                                      // R11
              end
              else
                st_q <= ST_RX;
            end
          end
          ST_TX:
          begin
            if (scl_fall & ckp_q & (cnt_q < 4'd8))
            begin
              sr_q  <= {sr_q[6:0], 1'b0};                           // R13
              cnt_q <= cnt_q + 4'd1;
              if (cnt_q == 4'd7)
                st_q <= ST_TXACK;
            end
          end
          ST_TXACK:
          begin
            if (scl_rise)
            begin
              if (sda_s)
              begin
                // NACK: transfer over, wait for next Start
                st_q <= ST_IDLE;                                    // R14
                rw_q <= 1'b0;
                da_q <= 1'b0;
                ua_q <= 1'b0;
                bf_q <= 1'b0;
              end
            end
            else if (scl_fall)
            begin
              flag_q <= 1'b1;                                       // R10
              ckp_q  <= 1'b0;                                       // R12
              cnt_q  <= 4'd0;
              st_q   <= ST_TX;
            end
          end
          ST_SKIP:
          begin
            // Not addressed: only count bytes for firmware master
            if (scl_rise)
              cnt_q <= cnt_q + 4'd1;
            else if (scl_fall & (cnt_q == 4'd9))
            begin
              cnt_q <= 4'd0;
              if (fw_mstr)
                flag_q <= 1'b1;                                     // R19
            end
          end
          default:
            st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive: level always low, enable alone moves the line
  // Stretching relies on the master reading SCL back
  // ----------------------------------------------------------------
  wire hold_ua  = ua_q & (st_q == ST_RX) & ~scl_s;                  // R8
  wire hold_tx  = in_tx & ~ckp_q & ~scl_s;                          // R11 R12 R24 R15
  wire sda_low  = ((st_q == ST_ACK) & ack_q) | (in_tx & ~sr_q[7]);  // R4 R13

  assign scl_o = 1'b0;                                              // R18
  assign sda_o = 1'b0;                                              // R18

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      irq_o    <= 1'b0;
    end
    else
    begin
      scl_oe_o <= ~tris_q[`TRIS_SCL] | (slave_en & (hold_ua | hold_tx)); // R18 R21
      sda_oe_o <= ~tris_q[`TRIS_SDA] | (slave_en & sda_low);             // R18 R22
      irq_o    <= gic_q[`GIC_GIE] & gic_q[`GIC_PEIE] & ie_q & flag_q;
    end
  end

endmodule // ssp_i2c_slave

/* File: rtl/ssp_i2c_regs.vh */
// Register map, field positions and mode codes of the two-wire serial port
//
// Numbered rules, referred to as R1 to R26 in the code
// R1 - After enable, wait Start, shift eight bits
// R2 - Sample SDA on every rising SCL edge
// R3 - Compare shift bits 7:1 on eighth falling edge
// R4 - Match, buffer free: load, set full, ACK, flag
// R5 - Full or overflow: no load, no ACK, flag
// R6 - Ten-bit first byte is 11110 A9 A8 0
// R7 - Master sends first ten-bit byte as write
// R8 - Ten-bit address byte: flags, update-address, hold SCL
// R9 - Read-direction clear: clear direction, buffer the address
// R10 - Flag every data byte, software clears it
// R11 - Read-direction set: set direction, ACK, hold SCL
// R12 - Transmit: buffer write loads shifter, release holds
// R13 - Transmit bits shift out on falling SCL
// R14 - Latch master ACK on ninth rise; NACK resets
// R15 - Master checks SCL before next pulse
// R16 - Start/Stop flags cleared on reset, disable; tracked
// R17 - Firmware master takes bus only when free
// R18 - Firmware drives lines low, direction bit only
// R19 - Master mode flags Start, Stop and bytes
// R20 - Busy bus: interrupt raised at next Stop
// R21 - Losing master releases both lines
// R22 - Slave keeps receiving after lost arbitration
// R23 - Four-bit mode field selects the bus mode
// R24 - Clock-release one frees SCL, zero holds
// R25 - Buffer read clears full; overflow by write
// R26 - Start and Stop detected from synced samples
`ifndef SSP_I2C_REGS_VH
`define SSP_I2C_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define GIC_IDX  10'h00b
`define PIRF_IDX 10'h00c
`define BUF_IDX  10'h013
`define CON_IDX  10'h014
`define TRIS_IDX 10'h086
`define PIEN_IDX 10'h08c
`define ADR_IDX  10'h093
`define STAT_IDX 10'h094

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GIC_RST  8'h00
`define CON_RST  8'h00
`define TRIS_RST 8'hff
`define ADR_RST  8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GIC_GIE   7
`define GIC_PEIE  6
`define PIR_FLAG  3
`define CON_WCOL  7
`define CON_OV    6
`define CON_EN    5
`define CON_CKP   4
`define TRIS_SCL  4
`define TRIS_SDA  1

// ----------------------------------------------------------------
// Mode codes and address pattern
// ----------------------------------------------------------------
`define MODE_S7    4'h6
`define MODE_S10   4'h7
`define MODE_FWM   4'hb
`define MODE_S7SP  4'he
`define MODE_S10SP 4'hf
`define TEN_PREFIX 5'h1e

`endif

/* File: rtl/line_sync.v */
// Two-flop synchroniser and edge/condition finder for the bus lines
`timescale 1ns/1ps
module line_sync (
  input  wire sys_clk_i,
  input  wire rst_i,
  input  wire scl_i,
  input  wire sda_i,
  output wire scl_o,
  output wire sda_o,
  output wire scl_rise_o,
  output wire scl_fall_o,
  output wire start_o,
  output wire stop_o
);

  reg [2:0] scl_q;
  reg [2:0] sda_q;

  // ----------------------------------------------------------------
  // Sync chain; stage 0 feeds only stage 1
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end
    else
    begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end

  // Edges from synced stage against previous sample
  assign scl_o      = scl_q[1];
  assign sda_o      = sda_q[1];
  assign scl_rise_o = scl_q[1] & ~scl_q[2];
  assign scl_fall_o = ~scl_q[1] & scl_q[2];
  // SDA moving while SCL stays high
  assign start_o    = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1]; // R26
  assign stop_o     = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1]; // R26

endmodule // line_sync

/* File: dv/ssp_i2c_slave_assertions.sv */
// Concurrent checks on the serial port's register bus and line drivers
`timescale 1ns/1ps
module ssp_i2c_slave_assertions (
  input wire        sys_clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire        scl_i,
  input wire        scl_o,
  input wire        scl_oe_o,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe_o,
  input wire        irq_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_needs_req: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
    else $error("ack without request");
  a_read_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_drive_level_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("line output level not low");
  // Data may only move while the clock line is low, or a master sees a false Start
  a_sda_moves_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed during clock high");
  a_stretch_on_low: assert property ($rose(scl_oe_o) |-> !scl_i)
    else $error("clock hold began while clock high");
  a_start_frees_sda: assert property (scl_i && $fell(sda_i) |=> !sda_oe_o [*8])
    else $error("data driven right after Start");

  // Main scenarios reached
  c_reg_write: cover property (ack_o && we_i);
  c_stretch: cover property ($rose(scl_oe_o));
  c_ack_drive: cover property ($rose(sda_oe_o));
  c_irq: cover property ($rose(irq_o));
endmodule // ssp_i2c_slave_assertions

bind ssp_i2c_slave ssp_i2c_slave_assertions i_chk (.sys_clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o,
  .ack_o, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o, .irq_o);

/* File: dv/i2c_bus_master_model.sv */
// Behavioural two-wire bus master pulling the lines low through open drain
`timescale 1ns/1ps
module i2c_bus_master_model (
  input  wire  scl_i,
  input  wire  sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Released at start; pull-ups in the bench make idle high
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  // One bit; waiting on the line lets a slave stretch the clock
  task automatic bit_cycle(input logic b, output logic r);
    sda_low_o = !b;
    #31;
    scl_low_o = 1'b0;
    wait (scl_i === 1'b1);
    r = sda_i;
    #62.5;
    scl_low_o = 1'b1;
    #31.5;
  endtask

  // Start, also repeated: data falls with clock high
  task automatic bus_start();
    sda_low_o = 1'b0;
    #31;
    scl_low_o = 1'b0;
    wait (scl_i === 1'b1);
    #31;
    sda_low_o = 1'b1;
    #31;
    scl_low_o = 1'b1;
    #31;
  endtask

  // Stop: data rises with clock high
  task automatic bus_stop();
    sda_low_o = 1'b1;
    #31;
    scl_low_o = 1'b0;
    wait (scl_i === 1'b1);
    #31;
    sda_low_o = 1'b0;
    #62;
  endtask

  // Byte out, MSB first; tail lets the slave's flags settle
  task automatic wr_byte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], r);
    bit_cycle(1'b1, nak);
    #80;
  endtask

  // Byte in, then our own acknowledge bit
  task automatic rd_byte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
    bit_cycle(nak, r);
    #80;
  endtask
endmodule // i2c_bus_master_model

/* File: dv/i2c_slave_with_start_stop_detect_test.sv */
// Self-checking bench for the two-wire serial port slave
`timescale 1ns/1ps
`include "ssp_i2c_regs.vh"
module i2c_slave_with_start_stop_detect_test;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0]  sel_i = 4'h1;
  logic [31:0] dat_i = 32'h00000000;
  wire  [31:0] dat_o;
  wire         ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, m_scl_low, m_sda_low;
  int          bad_count = 0;
  int          cmp_count = 0;
  logic [7:0]  q;
  logic        ak;
  logic [17:0] rows [0:7] = '{{`GIC_IDX, 8'h00}, {`PIRF_IDX, 8'h00}, {`CON_IDX, 8'h00},
    {`TRIS_IDX, 8'hff}, {`PIEN_IDX, 8'h00}, {`ADR_IDX, 8'h00}, {`STAT_IDX, 8'h00}, {10'h001, 8'h00}};
  // Pull-ups: a line is low when any party pulls it
  wire         scl_w = !(scl_oe_o | m_scl_low);
  wire         sda_w = !(sda_oe_o | m_sda_low);

  ssp_i2c_slave i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
  i2c_bus_master_model i_bus (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl_low), .sda_low_o(m_sda_low));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Classic cycle: hold until ack is seen, take data at that edge
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [7:0] r);
    @(posedge sys_clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    do @(posedge sys_clk_i); while (ack_o !== 1'b1);
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, output logic [7:0] r);
    wb(1'b0, idx, 8'h00, r);
  endtask
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished, %0d checks so far", name, cmp_count);
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial forever #5 sys_clk_i = ~sys_clk_i;
  // Whole run is about a dozen microseconds; allow ample margin
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(rows[i][17:8], q);
      chk("reset value", q, rows[i][7:0]);
    end
    done("reset values");
    wb(1'b1, `ADR_IDX, 8'ha4, q);
    wb(1'b1, `GIC_IDX, 8'hc0, q);
    wb(1'b1, `PIEN_IDX, 8'h08, q);
    wb(1'b1, `CON_IDX, 8'h3e, q);
    i_bus.bus_start();
    rd(`STAT_IDX, q);
    chk("start seen", q & 8'h18, 8'h08);
    rd(`PIRF_IDX, q);
    chk("start flag", q, 8'h08);
    // Clear so the byte flag below is the address byte's own
    wb(1'b1, `PIRF_IDX, 8'h00, q);
    i_bus.wr_byte(8'ha4, ak);
    chk("address ack", {7'h0, ak}, 8'h00);
    rd(`STAT_IDX, q);
    chk("status write", q & 8'h05, 8'h01);
    rd(`PIRF_IDX, q);
    chk("byte flag", q, 8'h08);
    chk("irq high", {7'h0, irq_o}, 8'h01);
    rd(`BUF_IDX, q);
    chk("address buffered", q, 8'ha4);
    rd(`STAT_IDX, q);
    chk("full cleared", q & 8'h01, 8'h00);
    wb(1'b1, `PIRF_IDX, 8'h00, q);
    rd(`PIRF_IDX, q);
    chk("irq low", {7'h0, irq_o}, 8'h00);
    i_bus.wr_byte(8'h3c, ak);
    chk("data ack", {7'h0, ak}, 8'h00);
    wb(1'b1, `PIRF_IDX, 8'h00, q);
    // Buffer left unread, so this byte must be refused
    i_bus.wr_byte(8'hc3, ak);
    chk("full nack", {7'h0, ak}, 8'h01);
    rd(`PIRF_IDX, q);
    chk("flag on nack", q, 8'h08);
    rd(`CON_IDX, q);
    chk("overflow set", q, 8'h7e);
    rd(`BUF_IDX, q);
    chk("buffer kept", q, 8'h3c);
    i_bus.bus_stop();
    rd(`STAT_IDX, q);
    chk("stop seen", q & 8'h18, 8'h10);
    done("receive");
    wb(1'b1, `CON_IDX, 8'h2e, q);
    rd(`CON_IDX, q);
    chk("overflow cleared", q, 8'h2e);
    wb(1'b1, `PIRF_IDX, 8'h00, q);
    i_bus.bus_start();
    i_bus.wr_byte(8'h40, ak);
    chk("other address", {7'h0, ak}, 8'h01);
    i_bus.bus_start();
    i_bus.wr_byte(8'ha5, ak);
    chk("read address ack", {7'h0, ak}, 8'h00);
    for (int i = 0; i < 40 && scl_oe_o !== 1'b1; i++) @(posedge sys_clk_i);
    chk("clock held", {7'h0, scl_oe_o}, 8'h01);
    rd(`STAT_IDX, q);
    chk("direction set", q & 8'h04, 8'h04);
    rd(`BUF_IDX, q);
    chk("read address buffered", q, 8'ha5);
    wb(1'b1, `BUF_IDX, 8'h96, q);
    chk("held until release", {7'h0, scl_oe_o}, 8'h01);
    wb(1'b1, `CON_IDX, 8'h3e, q);
    i_bus.rd_byte(1'b1, q);
    chk("sent byte", q, 8'h96);
    rd(`STAT_IDX, q);
    chk("nack resets", q & 8'h07, 8'h00);
    i_bus.bus_stop();
    done("transmit");
    // Ten-bit write address; each byte holds SCL until rewritten
    wb(1'b1, `CON_IDX, 8'h27, q);
    wb(1'b1, `ADR_IDX, 8'hf0, q);
    i_bus.bus_start();
    i_bus.wr_byte(8'hf0, ak);
    chk("high address ack", {7'h0, ak}, 8'h00);
    chk("address hold", {7'h0, scl_oe_o}, 8'h01);
    rd(`STAT_IDX, q);
    chk("update flagged", q & 8'h03, 8'h03);
    wb(1'b1, `ADR_IDX, 8'h5a, q);
    rd(`BUF_IDX, q);
    chk("address release", {7'h0, scl_oe_o}, 8'h00);
    i_bus.wr_byte(8'h5a, ak);
    chk("low address ack", {7'h0, ak}, 8'h00);
    wb(1'b1, `ADR_IDX, 8'hf0, q);
    rd(`BUF_IDX, q);
    chk("low address buffered", q, 8'h5a);
    // Direction bit alone pulls data; SCL held low, so no false Start
    wb(1'b1, `TRIS_IDX, 8'hfd, q);
    rd(`TRIS_IDX, q);
    chk("direction drives", {7'h0, sda_oe_o}, 8'h01);
    wb(1'b1, `TRIS_IDX, 8'hff, q);
    rd(`TRIS_IDX, q);
    chk("lines released", {7'h0, sda_oe_o}, 8'h00);
    i_bus.bus_stop();
    done("ten-bit");
    wb(1'b1, `CON_IDX, 8'h00, q);
    rd(`STAT_IDX, q);
    chk("disable clears", q & 8'h18, 8'h00);
    done("disable");
    complete_run();
  end
endmodule // i2c_slave_with_start_stop_detect_test
